// [rtl/fault_check_unit.sv]
// exception checks and machine-check bank model registers
`timescale 1ns/1ps
`include "fault_check_consts.svh"
module fault_check_unit #(
   parameter int BANKS = `BANK_COUNT
) (
   input wire logic CLK,
   input wire logic RST_N,
   input fault_check_pkg::instr_s INSTR,
   input wire logic MC_LOG,
   input wire logic [1:0] MC_BANK,
   input wire logic [15:0] MC_ARCH,
   input wire logic [15:0] MC_MODEL,
   output fault_check_pkg::result_s RESULT
);
   import fault_check_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // register storage
   logic [15:0] arch_code [BANKS];
   logic [15:0] model_code [BANKS];
   logic [31:0] upper [BANKS];
   logic [63:0] bank_ctl [BANKS];
   logic [63:0] status_view [BANKS];
   logic [BANKS-1:0] hw_log;

   // index decode shared by read and write paths
   function automatic logic idx_valid(input logic [31:0] idx);
      idx_valid = (idx >= `MODEL_REG_FIRST) && (idx <= `MODEL_REG_LAST);
   endfunction
   function automatic logic [1:0] idx_bank(input logic [31:0] idx);
      idx_bank = idx[3:2];
   endfunction
   // slot inside a bank: control, status, two spares
   function automatic logic [1:0] idx_slot(input logic [31:0] idx);
      idx_slot = idx[1:0];
   endfunction

   genvar g;
   generate
      for (g = 0; g < BANKS; g++) begin : g_bank
         bank_status_fmt #(.BANK(g)) u_fmt (
            .ARCH_CODE(arch_code[g]),
            .MODEL_CODE(model_code[g]),
            .UPPER(upper[g]),
            .STATUS(status_view[g])
         );
         assign hw_log[g] = MC_LOG && (MC_BANK == 2'(g));
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // combinational decision
   logic valid_idx;
   logic is_model_op;
   logic prot_index;
   logic prot_mode;
   logic ld_fault;
   logic pf_store;
   logic fault;
   logic sw_write;
   logic [1:0] bank;
   logic [1:0] sel;
   logic [63:0] rd_value;

   assign is_model_op = INSTR.op == OP_READ_MODEL || INSTR.op == OP_WRITE_MODEL;
   assign valid_idx = idx_valid(INSTR.index); // [RULE_03]
   assign bank = idx_bank(INSTR.index);
   assign sel = idx_slot(INSTR.index);
   assign prot_index = is_model_op && !valid_idx; // [RULE_04]
   // mode alone decides; the guard bit is never looked at here
   assign prot_mode = INSTR.mov_debug_reg && INSTR.virt_8086; // [RULE_05] [RULE_06]
   assign ld_fault = INSTR.has_load && (INSTR.cs_limit_viol || INSTR.wait_fp_fault); // [RULE_08]
   assign pf_store = INSTR.store_page_fault;
   assign fault = prot_index || prot_mode || ld_fault || pf_store;
   // any fault blocks the write, so a restart finds the old contents
   assign sw_write = INSTR.valid && INSTR.op == OP_WRITE_MODEL && !fault; // [RULE_11]

   // read mux: control, status, and zero for unused slots
   always_comb begin
      rd_value = 64'h0;
      if (sel == `CTL_SLOT) begin
         rd_value = bank_ctl[bank];
      end else if (sel == `STATUS_SLOT) begin
         rd_value = status_view[bank];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bank control registers, only written by a valid write
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         for (int i = 0; i < BANKS; i++) begin
            bank_ctl[i] <= 64'h0;
         end
      end else if (sw_write && sel == `CTL_SLOT) begin
         bank_ctl[bank] <= INSTR.wdata; // [RULE_04]
      end
   end

   // status fields: hardware log wins over software write to the same bank
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         for (int i = 0; i < BANKS; i++) begin
            arch_code[i] <= 16'h0;
            model_code[i] <= 16'h0;
            upper[i] <= 32'h0;
         end
      end else begin
         for (int i = 0; i < BANKS; i++) begin
            if (hw_log[i]) begin
               arch_code[i] <= MC_ARCH;
               model_code[i] <= MC_MODEL;
               upper[i][`VALID_BIT] <= 1'b1; // valid flag
            end else if (sw_write && sel == `STATUS_SLOT && bank == 2'(i)) begin
               // software writes in the bank's own layout
               upper[i] <= INSTR.wdata[63:32];
               if (i == `BANK_TWO) begin
                  model_code[i] <= INSTR.wdata[15:0]; // [RULE_02]
                  arch_code[i] <= INSTR.wdata[31:16];
               end else begin
                  arch_code[i] <= INSTR.wdata[15:0]; // [RULE_01]
                  model_code[i] <= INSTR.wdata[31:16];
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // answer registers, each loaded one cycle after the instruction is presented
   logic res_valid;
   logic res_fault;
   logic [7:0] res_vector;
   logic [15:0] res_code;
   logic [63:0] res_rdata;
   logic [31:0] res_ip;
   logic [31:0] res_esp;
   logic res_trap;
   logic res_load;
   logic res_store;
   logic res_commit;
   logic retire;
   logic call_taken;

   // a clean instruction retires; a faulting one leaves nothing but the fault
   assign retire = INSTR.valid && !fault; // [RULE_11]
   assign call_taken = retire && INSTR.near_call;

   // answer strobe follows the request by exactly one cycle
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         res_valid <= 1'b0;
      end else begin
         res_valid <= INSTR.valid;
      end
   end

   // fault report: protection beats load faults, which beat the store page fault
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         res_fault <= 1'b0;
         res_vector <= 8'h00;
         res_code <= 16'h0000;
      end else begin
         res_fault <= INSTR.valid && fault;
         res_vector <= 8'h00;
         res_code <= 16'h0000;
         if (INSTR.valid) begin
            if (prot_mode || prot_index) begin
               // protection fault wins, so no debug trap can be raised
               res_vector <= `VEC_PROTECT; // [RULE_05] [RULE_06]
               res_code <= `FAULT_CODE_ZERO; // [RULE_04]
            end else if (ld_fault) begin
               // load suppressed: side-effect memory never sees it
               res_vector <= INSTR.cs_limit_viol ? `VEC_PROTECT : `VEC_FLOAT; // [RULE_08]
            end else if (pf_store) begin
               res_vector <= `VEC_PAGE; // [RULE_09]
            end
         end
      end
   end

   // memory traffic only once nothing in the instruction can fault
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         res_commit <= 1'b0;
         res_load <= 1'b0;
         res_store <= 1'b0;
      end else begin
         res_commit <= retire; // [RULE_11]
         // store translation is known good before the read goes out, so no repeat read
         res_load <= retire && (INSTR.has_load || INSTR.read_modify_write); // [RULE_08] [RULE_09]
         res_store <= retire && INSTR.read_modify_write; // [RULE_09]
      end
   end

   // read data, zero unless a clean model register read
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         res_rdata <= 64'h0;
      end else if (retire && INSTR.op == OP_READ_MODEL) begin
         res_rdata <= rd_value; // [RULE_03]
      end else begin
         res_rdata <= 64'h0;
      end
   end

   // pointers: a call moves both even when a breakpoint hits its push
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         res_ip <= 32'h0;
         res_esp <= 32'h0;
         res_trap <= 1'b0;
      end else if (call_taken) begin
         res_ip <= INSTR.call_target; // [RULE_07]
         res_esp <= INSTR.esp - `PUSH_BYTES; // [RULE_07]
         // breakpoint is reported after the call, never instead of it
         res_trap <= INSTR.bkpt_on_push; // [RULE_07]
      end else begin
         // faulting path keeps ip and stack as they were
         res_ip <= INSTR.next_ip; // [RULE_11]
         res_esp <= INSTR.esp;
         res_trap <= 1'b0;
      end
   end

   // gather the answer; every field comes straight from a flip-flop
   assign RESULT = '{
      valid: res_valid,
      fault: res_fault,
      vector: res_vector,
      code: res_code,
      rdata: res_rdata,
      new_ip: res_ip,
      new_esp: res_esp,
      dbg_trap: res_trap,
      load_issue: res_load,
      store_issue: res_store,
      commit: res_commit
   };
endmodule

// [rtl/fault_check_consts.svh]
// constants for the fault and check status logic
// Functional notes
// RULE_01 - generic bank status: architecture code bits 15:0, model code bits 31:16
// RULE_02 - bank two status only: model code low half, architecture code high half
// RULE_03 - model register access selects by ECX index; reads return EDX:EAX
// RULE_04 - reserved or unimplemented index refused with protection fault code zero, no change
// RULE_05 - debug register move in virtual-8086 mode raises protection fault
// RULE_06 - that protection fault wins over guard bit; no debug exception then
// RULE_07 - breakpoint on call push still updates stack and jumps to target
// RULE_08 - load in limit-violating or faulting waiting float instruction is never issued
// RULE_09 - uncached read-modify-write read issued only once store translation is known good
// RULE_10 - software should use simple loads and stores for side-effect memory
// RULE_11 - faulting instruction leaves registers and memory untouched for clean restart
`ifndef FAULT_CHECK_CONSTS_SVH
`define FAULT_CHECK_CONSTS_SVH
`define BANK_COUNT 4
`define MODEL_REG_FIRST 32'h0000_0400
`define MODEL_REG_LAST 32'h0000_040f
`define CTL_SLOT 2'h0
`define STATUS_SLOT 2'h1
`define VALID_BIT 31
`define PUSH_BYTES 32'h0000_0004
`define BANK_TWO 2
`define ARCH_LO 0
`define MODEL_LO 16
`define CODE_W 16
`define VEC_DEBUG 8'h01
`define VEC_PROTECT 8'h0d
`define VEC_PAGE 8'h0e
`define VEC_FLOAT 8'h10
`define FAULT_CODE_ZERO 16'h0000
`endif

// [rtl/fault_check_pkg.sv]
// types for the fault and check status logic
package fault_check_pkg;
   typedef enum logic [1:0] {OP_NONE = 2'h0, OP_READ_MODEL = 2'h1, OP_WRITE_MODEL = 2'h3,
      OP_OTHER = 2'h2} op_e;
   typedef struct packed {
      logic valid;
      op_e op;
      logic [31:0] index;
      logic [63:0] wdata;
      logic mov_debug_reg;
      logic virt_8086;
      logic guard_bit;
      logic near_call;
      logic bkpt_on_push;
      logic [31:0] call_target;
      logic [31:0] next_ip;
      logic [31:0] esp;
      logic has_load;
      logic cs_limit_viol;
      logic wait_fp_fault;
      logic read_modify_write;
      logic uncached;
      logic store_page_fault;
   } instr_s;
   typedef struct packed {
      logic valid;
      logic fault;
      logic [7:0] vector;
      logic [15:0] code;
      logic [63:0] rdata;
      logic [31:0] new_ip;
      logic [31:0] new_esp;
      logic dbg_trap;
      logic load_issue;
      logic store_issue;
      logic commit;
   } result_s;
endpackage

// [rtl/bank_status_fmt.sv]
// machine-check bank status packing per bank
`timescale 1ns/1ps
`include "fault_check_consts.svh"
module bank_status_fmt #(
   parameter int BANK = 0
) (
   input wire logic [15:0] ARCH_CODE,
   input wire logic [15:0] MODEL_CODE,
   input wire logic [31:0] UPPER,
   output logic [63:0] STATUS
);
   // bank two swaps the halves; keep that quirk visible to software
   generate
      if (BANK == `BANK_TWO) begin : g_swap
         assign STATUS = {UPPER, ARCH_CODE, MODEL_CODE}; // [RULE_02]
      end else begin : g_norm
         assign STATUS = {UPPER, MODEL_CODE, ARCH_CODE}; // [RULE_01]
      end
   endgenerate
endmodule

// [sim/fault_check_unit_assertions.sv]
// port checker for the fault and check status logic
`timescale 1ns/1ps
`include "fault_check_consts.svh"
module fault_check_unit_assertions #(
   parameter int BANKS = 4
) (
   input wire logic CLK,
   input wire logic RST_N,
   input fault_check_pkg::instr_s INSTR,
   input wire logic MC_LOG,
   input wire logic [1:0] MC_BANK,
   input wire logic [15:0] MC_ARCH,
   input wire logic [15:0] MC_MODEL,
   input fault_check_pkg::result_s RESULT
);
   import fault_check_pkg::*;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   logic bad_idx;
   logic mode_dbg;
   logic clean_call;
   // helper terms, kept apart so each property reads short
   assign bad_idx = (INSTR.op == OP_READ_MODEL || INSTR.op == OP_WRITE_MODEL) &&
      (INSTR.index < `MODEL_REG_FIRST || INSTR.index > `MODEL_REG_LAST);
   assign mode_dbg = INSTR.valid && INSTR.virt_8086 && INSTR.mov_debug_reg;
   assign clean_call = INSTR.valid && INSTR.near_call && INSTR.op == OP_OTHER &&
      !INSTR.mov_debug_reg && !INSTR.has_load && !INSTR.store_page_fault;
   ////////////////////////////////////////////////////////////////////////////////
   a_answer_next: assert property (INSTR.valid |=> RESULT.valid)
      else $error("answer missing one cycle after request");
   a_bad_index: assert property (INSTR.valid && bad_idx |=> RESULT.fault &&
      RESULT.vector == `VEC_PROTECT && RESULT.code == `FAULT_CODE_ZERO && !RESULT.commit)
      else $error("bad index not refused");
   a_mode_protect: assert property (mode_dbg |=> RESULT.vector == `VEC_PROTECT)
      else $error("debug move in virtual-8086 mode not protected");
   a_no_debug_trap: assert property (mode_dbg && INSTR.guard_bit |=>
      RESULT.fault && !RESULT.dbg_trap)
      else $error("debug trap raised in virtual-8086 mode");
   a_call_target: assert property (clean_call |=> RESULT.new_ip == $past(INSTR.call_target)
      && RESULT.new_esp == $past(INSTR.esp) - 32'h4)
      else $error("call target or stack wrong");
   a_early_load: assert property (INSTR.valid && INSTR.has_load &&
      (INSTR.cs_limit_viol || INSTR.wait_fp_fault) |=> RESULT.fault && !RESULT.load_issue)
      else $error("load issued before fault");
   a_uncached_read_once: assert property (INSTR.valid && INSTR.read_modify_write &&
      INSTR.uncached &&
      INSTR.store_page_fault |=> !RESULT.load_issue)
      else $error("uncached read issued before store fault");
   a_fault_clean: assert property (RESULT.fault |-> !RESULT.commit && !RESULT.store_issue)
      else $error("faulting instruction committed");
   a_fault_restore: assert property (INSTR.valid |=> !RESULT.fault ||
      RESULT.new_ip == $past(INSTR.next_ip) && RESULT.new_esp == $past(INSTR.esp))
      else $error("fault moved ip or stack");
   c_bad: cover property (INSTR.valid && bad_idx);
   c_mode: cover property (mode_dbg);
   c_call: cover property (clean_call);
endmodule
bind fault_check_unit fault_check_unit_assertions #(.BANKS(BANKS)) chk_u (.CLK(CLK),
   .RST_N(RST_N), .INSTR(INSTR), .MC_LOG(MC_LOG), .MC_BANK(MC_BANK), .MC_ARCH(MC_ARCH),
   .MC_MODEL(MC_MODEL), .RESULT(RESULT));

// [sim/test_fault_and_check_status_logic.sv]
// self-checking bench for the fault and check status logic
`timescale 1ns/1ps
`include "fault_check_consts.svh"
module test_fault_and_check_status_logic;
   import fault_check_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   instr_s instr = '0;
   logic mc_log = 1'b0;
   logic [1:0] mc_bank = 2'h0;
   logic [15:0] mc_arch = 16'h0000;
   logic [15:0] mc_model = 16'h0000;
   // odd entries are writes aimed at bank zero slots, so a leak would show on read-back
   logic [31:0] bad [4] = '{32'h0000_03ff, 32'h0000_0411, 32'h0000_0410, 32'h0401_0000};
   result_s res;
   result_s got;
   instr_s i;
   int fail_count = 0;
   int total_checks = 0;
   always #2.5 clk = ~clk;
   fault_check_unit dut_u (.CLK(clk), .RST_N(rst_n), .INSTR(instr), .MC_LOG(mc_log),
      .MC_BANK(mc_bank), .MC_ARCH(mc_arch), .MC_MODEL(mc_model), .RESULT(res));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] seen);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // answer stands one cycle only, so it is captured right after that edge
   task automatic run(input instr_s x);
      instr_s y;
      y = x;
      y.valid = 1'b1;
      @(posedge clk) #1;
      instr = y;
      @(posedge clk) #1;
      got = res;
      instr = '0;
   endtask
   task automatic log_err(input logic [1:0] b);
      @(posedge clk) #1;
      mc_log = 1'b1;
      mc_bank = b;
      mc_arch = 16'ha000 + 16'(b);
      mc_model = 16'hb000 + 16'(b);
      @(posedge clk) #1;
      mc_log = 1'b0;
   endtask
   task automatic chk_fault(input logic [7:0] v);
      chk("valid", 64'h1, 64'(got.valid));
      chk("fault", 64'h1, 64'(got.fault));
      chk("vector", 64'(v), 64'(got.vector));
      chk("commit", 64'h0, 64'(got.commit));
      chk("load_issue", 64'h0, 64'(got.load_issue));
      chk("store_issue", 64'h0, 64'(got.store_issue));
   endtask
   // clean retirement with the expected memory traffic
   task automatic chk_done(input logic ld, input logic st);
      chk("valid", 64'h1, 64'(got.valid));
      chk("fault", 64'h0, 64'(got.fault));
      chk("commit", 64'h1, 64'(got.commit));
      chk("load_issue", 64'(ld), 64'(got.load_issue));
      chk("store_issue", 64'(st), 64'(got.store_issue));
   endtask
   // one model register access
   task automatic access(input op_e op, input logic [31:0] idx, input logic [63:0] wd);
      i = '0;
      i.op = op;
      i.index = idx;
      i.wdata = wd;
      run(i);
   endtask
   task automatic read_status(input int b);
      i = '0;
      i.op = OP_READ_MODEL;
      i.index = 32'h0000_0401 + 32'(4 * b);
      run(i);
      chk("status", (b == 2) ? {32'h1, 16'ha002, 16'hb002} :
         {32'h1, 16'hb000 + 16'(b), 16'ha000 + 16'(b)}, {31'h0, got.rdata[63], got.rdata[31:0]});
   endtask
   task automatic results;
      if (fail_count == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // watchdog, far beyond the roughly sixty cycles the tests need
   initial begin
      #20000;
      fail_count++;
      results();
   end
   // main sequence
   initial begin
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      for (int b = 0; b < 4; b++) begin
         log_err(2'(b));
         read_status(b);
      end
      // control slot round trip and a spare slot that reads zero
      access(OP_WRITE_MODEL, 32'h0000_0404, 64'h0123_4567_89ab_cdef);
      chk_done(1'b0, 1'b0);
      access(OP_READ_MODEL, 32'h0000_0404, 64'h0);
      chk("control", 64'h0123_4567_89ab_cdef, got.rdata);
      access(OP_READ_MODEL, 32'h0000_0402, 64'h0);
      chk("spare slot", 64'h0, got.rdata);
      for (int k = 0; k < 4; k++) begin
         i = '0;
         i.op = k[0] ? OP_WRITE_MODEL : OP_READ_MODEL;
         i.index = bad[k];
         i.wdata = '1;
         run(i);
         chk_fault(`VEC_PROTECT);
         chk("code", 64'h0, 64'(got.code));
      end
      read_status(0);
      access(OP_READ_MODEL, 32'h0000_0400, 64'h0);
      chk("control untouched", 64'h0, got.rdata);
      i = '0;
      i.op = OP_OTHER;
      i.mov_debug_reg = 1'b1;
      i.virt_8086 = 1'b1;
      i.guard_bit = 1'b1;
      run(i);
      chk_fault(`VEC_PROTECT);
      chk("dbg_trap", 64'h0, 64'(got.dbg_trap));
      i = '0;
      i.op = OP_OTHER;
      i.near_call = 1'b1;
      i.bkpt_on_push = 1'b1;
      i.call_target = 32'h0000_2000;
      i.next_ip = 32'h0000_1005;
      i.esp = 32'h0000_8000;
      run(i);
      chk("call", {32'h0000_2000, 32'h0000_7ffc}, {got.new_ip, got.new_esp});
      chk("call trap", 64'h1, 64'(got.dbg_trap));
      chk_done(1'b0, 1'b0);
      for (int k = 0; k < 2; k++) begin
         i = '0;
         i.op = OP_OTHER;
         i.has_load = 1'b1;
         i.cs_limit_viol = (k == 0);
         i.wait_fp_fault = (k == 1);
         run(i);
         chk_fault((k == 0) ? `VEC_PROTECT : `VEC_FLOAT);
      end
      i = '0;
      i.op = OP_OTHER;
      i.read_modify_write = 1'b1;
      i.uncached = 1'b1;
      i.store_page_fault = 1'b1;
      i.next_ip = 32'h0000_3000;
      i.esp = 32'h0000_9000;
      run(i);
      chk_fault(`VEC_PAGE);
      chk("restore", {32'h0000_3000, 32'h0000_9000}, {got.new_ip, got.new_esp});
      // side-effect memory reached by a plain load: one read, no write; then by a read-modify-write: one read, one write
      i = '0;
      i.op = OP_OTHER;
      i.has_load = 1'b1;
      i.uncached = 1'b1;
      run(i);
      chk_done(1'b1, 1'b0);
      i.has_load = 1'b0;
      i.read_modify_write = 1'b1;
      run(i);
      chk_done(1'b1, 1'b1);
      // mid-run reset, then bank two status and bank one control read back zero
      @(posedge clk) #1;
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      access(OP_READ_MODEL, 32'h0000_0409, 64'h0);
      chk("status after reset", 64'h0, got.rdata);
      access(OP_READ_MODEL, 32'h0000_0404, 64'h0);
      chk("control after reset", 64'h0, got.rdata);
      results();
   end
endmodule
